// ===== src/crs_pkg.sv
package crs_pkg;

  // ----------------------------------------------------------------
  // bus geometry and answers
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam int R_FLAG     = 0;
  localparam int R_IP       = 1;
  localparam int R_CS_SEL   = 2;
  localparam int R_CS_BASE  = 3;
  localparam int R_CS_LIM   = 4;
  localparam int R_FS_SEL   = 5;
  localparam int R_FS_BASE  = 6;
  localparam int R_FS_LIM   = 7;
  localparam int R_GS_SEL   = 8;
  localparam int R_GS_BASE  = 9;
  localparam int R_GS_LIM   = 10;
  localparam int R_APP_LAST = 10;
  localparam int R_IDT_BASE = 11;
  localparam int R_IDT_LIM  = 12;
  localparam int R_GDT_BASE = 13;
  localparam int R_GDT_LIM  = 14;
  localparam int R_LDT_SEL  = 15;
  localparam int R_TR_SEL   = 16;
  localparam int R_CR0      = 17;
  localparam int R_CR2      = 18;
  localparam int R_CR3      = 19;
  localparam int R_CR4      = 20;
  localparam int R_DR7      = 21;
  localparam int R_CCR0     = 22;
  localparam int R_CCR4     = 26;
  localparam int R_CCR6     = 28;
  localparam int R_ARR0     = 29;
  localparam int R_ARR7     = 36;
  localparam int R_RCR0     = 37;
  localparam int R_RCR7     = 44;
  localparam int N_STORE    = 45;
  localparam int R_INFO     = 46;
  localparam int R_STAT     = 47;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] FLAG_RST    = 32'h0000_0002;
  localparam logic [31:0] IP_RST      = 32'h0000_fff0;
  localparam logic [31:0] CS_SEL_RST  = 32'h0000_f000;
  localparam logic [31:0] CS_BASE_RST = 32'hffff_0000;
  localparam logic [31:0] SEG_LIM_RST = 32'h0000_ffff;
  localparam logic [31:0] ZERO_RST    = 32'h0000_0000;
  localparam logic [31:0] IDT_LIM_RST = 32'h0000_03ff;
  localparam logic [31:0] CR0_RST     = 32'h6000_0010;
  localparam logic [31:0] CR4_RST     = 32'h0000_0000;
  localparam logic [31:0] DR7_RST     = 32'h0000_0400;
  localparam logic [31:0] CCR_RST     = 32'h0000_0000;
  localparam logic [31:0] CCR4_RST    = 32'h0000_0080;
  localparam logic [31:0] REGION_RST  = 32'h0000_0000;
  localparam logic [31:0] NUM_ARCH    = 32'h0000_003a;
  localparam logic [31:0] MASK_8      = 32'h0000_00ff;
  localparam logic [31:0] MASK_16     = 32'h0000_ffff;
  localparam logic [31:0] MASK_32     = 32'hffff_ffff;

  // ----------------------------------------------------------------
  // field positions and timing
  // ----------------------------------------------------------------
  localparam int          CCR1_IDX     = 23;
  localparam int          WEAK_ALL_BIT = 4;
  localparam int          RCR_EN_BIT   = 0;
  localparam int          RCR_WEAK_BIT = 1;
  localparam int          STAT_FETCHED = 0;
  localparam int          STAT_LOCKED  = 1;
  localparam int          STAT_BUSY    = 2;
  localparam logic [31:0] FETCH_VEC    = 32'hffff_fff0;
  localparam logic [7:0]  FETCH_DELAY  = 8'hc8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {OP_NOP, OP_BIT_MOD, OP_XCHG, OP_UNARY, OP_BINARY, OP_OTHER} crs_op_t;
  typedef enum logic [1:0] {W_BYTE, W_FULL, W_F64, W_F80} crs_width_t;
  typedef enum logic [2:0] {SZ_8, SZ_16, SZ_32, SZ_64, SZ_80} crs_size_t;

  typedef struct packed {
    crs_op_t    op;
    logic [1:0] n_ops;
    logic       lock;
    logic       dst_mem;
    logic [1:0] size_pfx;
    logic       code32;
    crs_width_t width;
    logic [3:0] opc_len;
    logic [2:0] imm_len;
    logic [31:0] mem_addr;
  } crs_instr_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } crs_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } crs_axi_rsp_t;

endpackage

// ===== src/crs_top.sv
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
module crs_top (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // register bus
  input  wire crs_pkg::crs_axi_req_t axi_req,
  output crs_pkg::crs_axi_rsp_t      axi_rsp,
  input  wire logic [1:0]            cpl,
  // instruction issue
  input  wire logic                  instr_valid,
  output logic                       instr_ready,
  input  wire crs_pkg::crs_instr_t   instr,
  // memory sequencing
  output logic                       mem_start,
  output logic [31:0]                mem_addr,
  input  wire logic                  mem_done,
  output logic                       bus_lock_n,
  // results
  output logic                       ud_fault,
  output logic                       retire,
  output crs_pkg::crs_size_t         op_size,
  output logic [3:0]                 fetch_len,
  // reset fetch
  output logic                       fetch_start,
  output logic [31:0]                fetch_addr
);
  import crs_pkg::*;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [31:0] rst_val(input int i);
    case (i)
      R_FLAG:    rst_val = FLAG_RST;
      R_IP:      rst_val = IP_RST;
      R_CS_SEL:  rst_val = CS_SEL_RST;
      R_CS_BASE: rst_val = CS_BASE_RST;
      R_CS_LIM,
      R_FS_LIM,
      R_GS_LIM:  rst_val = SEG_LIM_RST;
      R_IDT_LIM: rst_val = IDT_LIM_RST;
      R_CR0:     rst_val = CR0_RST;
      R_CR4:     rst_val = CR4_RST;
      R_DR7:     rst_val = DR7_RST;
      R_CCR4:    rst_val = CCR4_RST;
      default:
      begin
        if (i >= R_CCR0 && i <= R_CCR6)
          rst_val = CCR_RST;
        else if (i >= R_ARR0 && i <= R_RCR7)
          rst_val = REGION_RST;
        else
          rst_val = ZERO_RST;
      end
    endcase
  endfunction

  function automatic logic has_rst(input int i);
    has_rst = !(i inside {R_GDT_BASE, R_GDT_LIM, R_LDT_SEL, R_TR_SEL, R_CR2, R_CR3});
  endfunction

  function automatic logic [31:0] reg_mask(input int i);
    if (i >= R_CCR0 && i <= R_RCR7)
      reg_mask = MASK_8;
    else if (i inside {R_CS_SEL, R_FS_SEL, R_GS_SEL, R_LDT_SEL, R_TR_SEL, R_IDT_LIM, R_GDT_LIM})
      reg_mask = MASK_16;
    else
      reg_mask = MASK_32;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb, input int i);
    logic [31:0] m;
    for (int b = 0; b < 4; b++)
      m[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    merge = m & reg_mask(i);
  endfunction

  function automatic logic lock_legal(input crs_op_t op);
    lock_legal = (op == OP_BIT_MOD) || (op == OP_XCHG) || (op == OP_UNARY) || (op == OP_BINARY);
  endfunction

  function automatic crs_size_t size_of(input crs_instr_t ins);
    case (ins.width)
      W_BYTE:  size_of = SZ_8;
      W_F64:   size_of = SZ_64;
      W_F80:   size_of = SZ_80;
      default: size_of = (ins.code32 ^ (ins.size_pfx != 2'h0)) ? SZ_32 : SZ_16;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {S_BOOT, S_IDLE, S_MEM} crs_state_t;

  crs_state_t  state_q;
  logic [31:0] regs_q [N_STORE];
  logic [31:0] regs_d [N_STORE];
  logic [7:0]  boot_cnt_q;
  logic        fetched_q;
  logic        lock_q;
  logic [4:0]  len_q;
  logic        mem_start_q;
  logic [31:0] mem_addr_q;
  logic        ud_q;
  logic        retire_q;
  crs_size_t   size_q;
  logic [3:0]  fetch_len_q;
  logic        fetch_start_q;
  logic        aw_have_q;
  logic        w_have_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  // ----------------------------------------------------------------
  // issue decode
  // ----------------------------------------------------------------
  logic        weak_rgn;
  wire         issue     = instr_valid && instr_ready;
  wire         lock_bad  = instr.lock && (!lock_legal(instr.op) || !instr.dst_mem);
  wire         weak_all  = regs_q[CCR1_IDX][WEAK_ALL_BIT];
  wire         go_mem    = issue && !lock_bad && instr.dst_mem;
  wire         go_now    = issue && !lock_bad && !instr.dst_mem;
  wire         lock_now  = go_mem && instr.lock && !weak_all && !weak_rgn;
  wire [4:0]   ins_len   = 5'(instr.opc_len) + 5'(instr.imm_len);
  wire         mem_end   = (state_q == S_MEM) && mem_done;
  wire [4:0]   adv_len   = mem_end ? len_q : ins_len;
  wire         advance   = go_now || mem_end;

  always_comb
  begin
    weak_rgn = 1'b0;
    for (int k = 0; k < 8; k++)
      if (regs_q[R_RCR0+k][RCR_EN_BIT] && regs_q[R_RCR0+k][RCR_WEAK_BIT]
          && regs_q[R_ARR0+k][7:0] == instr.mem_addr[31:24])
        weak_rgn = 1'b1;
  end

  assign instr_ready = (state_q == S_IDLE);

  // ----------------------------------------------------------------
  // register bus decode
  // ----------------------------------------------------------------
  wire [5:0]   wr_idx  = awaddr_q[7:2];
  wire [5:0]   rd_idx  = axi_req.araddr[7:2];
  wire         wr_fire = aw_have_q && w_have_q && !bvalid_q;
  wire         wr_map  = int'(wr_idx) < N_STORE;
  wire         wr_ok   = wr_map && (int'(wr_idx) <= R_APP_LAST || cpl == 2'h0);
  wire         rd_fire = axi_req.arvalid && !rvalid_q;
  wire         rd_reg  = int'(rd_idx) < N_STORE;
  wire         rd_map  = rd_reg || int'(rd_idx) == R_INFO || int'(rd_idx) == R_STAT;
  wire [31:0]  stat_w  = {29'h0, state_q == S_MEM, lock_q, fetched_q};
  wire [31:0]  rd_val  = rd_reg ? regs_q[rd_idx] :
                         int'(rd_idx) == R_INFO ? NUM_ARCH :
                         int'(rd_idx) == R_STAT ? stat_w : ZERO_RST;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_comb
  begin
    regs_d = regs_q;
    if (advance)
      regs_d[R_IP] = regs_q[R_IP] + 32'(adv_len);
    if (wr_fire && wr_ok)
      regs_d[wr_idx] = merge(regs_q[wr_idx], wdata_q, wstrb_q, int'(wr_idx));
  end

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < N_STORE; i++)
      if (!rstn && has_rst(i))
        regs_q[i] <= rst_val(i);
      else if (rstn)
        regs_q[i] <= regs_d[i];
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_q       <= S_BOOT;
      boot_cnt_q    <= 8'h00;
      fetched_q     <= 1'b0;
      fetch_start_q <= 1'b0;
      lock_q        <= 1'b0;
      len_q         <= 5'h00;
      mem_start_q   <= 1'b0;
      mem_addr_q    <= 32'h0000_0000;
      ud_q          <= 1'b0;
      retire_q      <= 1'b0;
      size_q        <= SZ_16;
      fetch_len_q   <= 4'h0;
    end
    else
    begin
      fetch_start_q <= 1'b0;
      mem_start_q   <= go_mem;
      ud_q          <= issue && lock_bad;
      retire_q      <= advance;
      case (state_q)
        S_BOOT:
        begin
          boot_cnt_q <= boot_cnt_q + 8'h01;
          if (boot_cnt_q == FETCH_DELAY - 8'h01)
          begin
            state_q       <= S_IDLE;
            fetch_start_q <= 1'b1;
            fetched_q     <= 1'b1;
          end
        end
        S_IDLE:
        begin
          if (issue)
          begin
            size_q      <= size_of(instr);
            fetch_len_q <= ins_len[3:0];
            len_q       <= ins_len;
          end
          if (go_mem)
          begin
            state_q    <= S_MEM;
            mem_addr_q <= instr.mem_addr;
            lock_q     <= lock_now;
          end
        end
        S_MEM:
        begin
          if (mem_done)
          begin
            state_q <= S_IDLE;
            lock_q  <= 1'b0;
          end
        end
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

  assign mem_start   = mem_start_q;
  assign mem_addr    = mem_addr_q;
  assign bus_lock_n  = !lock_q;
  assign ud_fault    = ud_q;
  assign retire      = retire_q;
  assign op_size     = size_q;
  assign fetch_len   = fetch_len_q;
  assign fetch_start = fetch_start_q;
  assign fetch_addr  = FETCH_VEC;

  // ----------------------------------------------------------------
  // register bus slave
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end
    else
    begin
      if (axi_req.awvalid && !aw_have_q)
      begin
        aw_have_q <= 1'b1;
        awaddr_q  <= axi_req.awaddr;
      end
      if (axi_req.wvalid && !w_have_q)
      begin
        w_have_q <= 1'b1;
        wdata_q  <= axi_req.wdata;
        wstrb_q  <= axi_req.wstrb;
      end
      if (wr_fire)
      begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_q && axi_req.bready)
        bvalid_q <= 1'b0;
      if (rd_fire)
      begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_val;
        rresp_q  <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_q && axi_req.rready)
        rvalid_q <= 1'b0;
    end
  end

  assign axi_rsp.awready = !aw_have_q;
  assign axi_rsp.wready  = !w_have_q;
  assign axi_rsp.bvalid  = bvalid_q;
  assign axi_rsp.bresp   = bresp_q;
  assign axi_rsp.arready = !rvalid_q;
  assign axi_rsp.rvalid  = rvalid_q;
  assign axi_rsp.rdata   = rdata_q;
  assign axi_rsp.rresp   = rresp_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  aux_seg_rst_a: assert property (!$past(rstn) |-> regs_q[R_FS_SEL] == ZERO_RST && regs_q[R_GS_BASE] == ZERO_RST
    && regs_q[R_FS_BASE] == ZERO_RST && regs_q[R_GS_SEL] == ZERO_RST
    && regs_q[R_FS_LIM] == SEG_LIM_RST && regs_q[R_GS_LIM] == SEG_LIM_RST)
    else $error("aux segment reset value wrong");
  idt_rst_a: assert property (!$past(rstn) |-> regs_q[R_IDT_BASE] == ZERO_RST
    && regs_q[R_IDT_LIM] == IDT_LIM_RST)
    else $error("interrupt table reset value wrong");
  ctrl_rst_a: assert property (!$past(rstn) |-> regs_q[R_CR0] == CR0_RST && regs_q[R_CR4] == CR4_RST
    && regs_q[R_DR7] == DR7_RST)
    else $error("control reset value wrong");
  cfg_rst_a: assert property (!$past(rstn) |-> regs_q[R_CCR4] == CCR4_RST && regs_q[R_CCR0] == CCR_RST
    && regs_q[R_ARR7] == REGION_RST && regs_q[R_RCR0] == REGION_RST)
    else $error("config reset value wrong");
  entry_rst_a: assert property (!$past(rstn) |-> regs_q[R_IP] == IP_RST && regs_q[R_FLAG] == FLAG_RST
    && regs_q[R_CS_SEL] == CS_SEL_RST && regs_q[R_CS_BASE] == CS_BASE_RST)
    else $error("entry state reset value wrong");
  fetch_time_a: assert property (!$past(rstn) |-> ##200 fetch_start && fetch_addr == FETCH_VEC)
    else $error("reset fetch not at expected cycle");
  lock_hold_a: assert property ((state_q == S_MEM && lock_q && !mem_done) |=> !bus_lock_n)
    else $error("bus lock dropped during locked access");
  lock_bad_a: assert property (issue && lock_bad |=> ud_fault && !mem_start && !retire)
    else $error("lock misuse not faulted");
  weak_lock_a: assert property (go_mem && (weak_all || weak_rgn) |=> bus_lock_n [*2])
    else $error("bus lock asserted under weak lock");
  op_size_a: assert property (issue && instr.width == W_FULL && !instr.code32 && instr.size_pfx != 2'h0
    |=> op_size == SZ_32)
    else $error("size prefix not applied");
  ip_step_a: assert property (retire && !$past(wr_fire) |-> regs_q[R_IP] == $past(regs_q[R_IP]) + 32'($past(adv_len)))
    else $error("instruction pointer not advanced");
  app_any_pl_a: assert property (wr_fire && int'(wr_idx) <= R_APP_LAST |=> bresp_q == RESP_OKAY)
    else $error("application register write refused");

  locked_rmw_c: cover property (mem_start && !bus_lock_n ##[1:20] retire);
  lock_fault_c: cover property (ud_fault);
  weak_lock_c: cover property (mem_start && bus_lock_n && $past(instr.lock));
  bus_write_c: cover property (bvalid_q && bresp_q == RESP_SLVERR);

endmodule

// ===== testbench/crs_mem_model.sv
module crs_mem_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // memory handshake
  input  wire logic       mem_start,
  input  wire logic [2:0] dly,
  output logic            mem_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;
  // ----------------------------------------
  // answers each memory phase dly+2 cycles later
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    mem_done <= 1'b0;
    if (!rstn)
      cnt_q <= 4'h0;
    else if (mem_start)
      cnt_q <= {1'b0, dly} + 4'h1;
    else if (cnt_q != 4'h0)
    begin
      cnt_q    <= cnt_q - 4'h1;
      mem_done <= (cnt_q == 4'h1);
    end
  end
endmodule

// ===== testbench/tb_crs_top.sv
module tb_crs_top;
  timeunit 1ns;
  timeprecision 1ns;
  import crs_pkg::*;
  logic         clk, rstn, iv, ir, ms, md, bl_n, ud, ret, fs, lk;
  logic [1:0]   cpl;
  logic [2:0]   dly;
  logic [3:0]   flen;
  logic [31:0]  ma, fa, ip, v;
  crs_axi_req_t rq;
  crs_axi_rsp_t rs;
  crs_instr_t   ins;
  crs_size_t    osz;
  int           n_errors, compares, cyc, boot, n_mem, n_iss, m;
  logic [33:0]  qr[$];
  logic [1:0]   qb[$];
  logic [8:0]   qi[$];
  logic [31:0]  qa[$];

  crs_top dut_u (.clk(clk), .rstn(rstn), .axi_req(rq), .axi_rsp(rs), .cpl(cpl), .instr_valid(iv),
    .instr_ready(ir), .instr(ins), .mem_start(ms), .mem_addr(ma), .mem_done(md), .bus_lock_n(bl_n),
    .ud_fault(ud), .retire(ret), .op_size(osz), .fetch_len(flen), .fetch_start(fs), .fetch_addr(fa));
  crs_mem_model mem_u (.clk(clk), .rstn(rstn), .mem_start(ms), .dly(dly), .mem_done(md));

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("compares %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  function automatic logic [31:0] rst_val(input int i);
    if (i == R_FLAG) return FLAG_RST;
    if (i == R_IP) return IP_RST;
    if (i == R_CS_SEL) return CS_SEL_RST;
    if (i == R_CS_BASE) return CS_BASE_RST;
    if (i inside {R_CS_LIM, R_FS_LIM, R_GS_LIM}) return SEG_LIM_RST;
    if (i == R_IDT_LIM) return IDT_LIM_RST;
    if (i == R_CR0) return CR0_RST;
    if (i == R_DR7) return DR7_RST;
    if (i == R_CCR4) return CCR4_RST;
    return ZERO_RST;
  endfunction

  function automatic crs_size_t sz(input crs_instr_t t);
    if (t.width == W_BYTE) return SZ_8;
    if (t.width == W_F64) return SZ_64;
    if (t.width == W_F80) return SZ_80;
    return (t.code32 ^ (t.size_pfx != 2'h0)) ? SZ_32 : SZ_16;
  endfunction

  // ----------------------------------------
  // bus and issue drivers
  // ----------------------------------------
  task automatic wr(input int i, input logic [31:0] d, input logic [1:0] r);
    logic a;
    logic w;
    a = 1;
    w = 1;
    qb.push_back(r);
    @(posedge clk);
    rq.awvalid <= 1;
    rq.awaddr  <= 8'(i * 4);
    rq.wvalid  <= 1;
    rq.wdata   <= d;
    rq.wstrb   <= 4'hf;
    while (a || w)
    begin
      @(posedge clk);
      if (a && rs.awready)
      begin
        a = 0;
        rq.awvalid <= 0;
      end
      if (w && rs.wready)
      begin
        w = 0;
        rq.wvalid <= 0;
      end
    end
    rq.bready <= 1;
    do @(posedge clk); while (!rs.bvalid);
    rq.bready <= 0;
  endtask

  task automatic rd(input int i, input logic [31:0] d, input logic [1:0] r);
    qr.push_back({r, d});
    @(posedge clk);
    rq.arvalid <= 1;
    rq.araddr  <= 8'(i * 4);
    do @(posedge clk); while (!rs.arready);
    rq.arvalid <= 0;
    rq.rready  <= 1;
    do @(posedge clk); while (!rs.rvalid);
    rq.rready <= 0;
  endtask

  task automatic iss(input crs_op_t op, input logic lock, input logic dst, input logic [31:0] a, input logic elk);
    crs_instr_t t;
    logic       f;
    t = '0;
    t.op = op;
    t.lock = lock;
    t.dst_mem = dst;
    t.mem_addr = a;
    t.n_ops = 2'($urandom_range(0, 3));
    t.size_pfx = 2'($urandom_range(0, 3));
    t.code32 = 1'($urandom);
    t.width = crs_width_t'(n_iss % 4);
    t.opc_len = 4'($urandom_range(1, 7));
    t.imm_len = 3'($urandom_range(0, 4));
    n_iss++;
    f = lock && (op == OP_NOP || op == OP_OTHER || !dst);
    qi.push_back({f, f | elk, 3'(sz(t)), t.opc_len + 4'(t.imm_len)});
    if (!f && dst) qa.push_back(a);
    if (!f) ip = ip + 32'(t.opc_len) + 32'(t.imm_len);
    @(posedge clk);
    ins <= t;
    iv  <= 1;
    do @(posedge clk); while (!ir);
    iv <= 0;
    do @(posedge clk); while (!(ret || ud));
  endtask

  always @(posedge clk)
  begin
    logic [8:0] e;
    if (rs.bvalid && rq.bready) chk(rs.bresp, qb.pop_front());
    if (rs.rvalid && rq.rready) chk({rs.rresp, rs.rdata}, qr.pop_front());
    if (ms)
    begin
      lk = bl_n;
      n_mem++;
      chk(ma, qa.pop_front());
    end
    if (ret || ud)
    begin
      e = qi.pop_front();
      if (e[8]) chk({ud, lk}, e[8:7]);
      else chk({ud, lk, 3'(osz), flen}, e);
      lk = 1;
    end
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      summarize();
    end
  end

  initial
  begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    wait (rstn);
    do begin @(posedge clk); boot++; end while (!fs && boot < 400);
    chk(boot >= 150 && boot <= 250, 1);
    chk(fa, FETCH_VEC);
  end

  initial
  begin
    rstn = 0;
    cpl = 0;
    dly = 0;
    iv = 0;
    rq = '0;
    ins = '0;
    ip = IP_RST;
    lk = 1;
    void'($urandom(62114));
    repeat (2) @(posedge clk);
    rstn <= 1;
    for (int i = 0; i < N_STORE; i++)
      if (!(i inside {[13:16], 18, 19})) rd(i, rst_val(i), RESP_OKAY);
    rd(R_INFO, NUM_ARCH, RESP_OKAY);
    rd(N_STORE, 0, RESP_SLVERR);
    rd(48, 0, RESP_SLVERR);
    $display("reset values done");
    cpl <= 2'h3;
    v = $urandom;
    wr(R_CR0, v, RESP_SLVERR);
    rd(R_CR0, CR0_RST, RESP_OKAY);
    wr(R_FS_SEL, v, RESP_OKAY);
    rd(R_FS_SEL, v & MASK_16, RESP_OKAY);
    cpl <= 2'h0;
    $display("privilege done");
    for (int k = 0; k < 8; k++)
      iss(crs_op_t'($urandom_range(0, 5)), 0, 0, 0, 1);
    m = n_mem;
    iss(OP_XCHG, 1, 0, 0, 1);
    for (int k = 0; k < 6; k++)
    begin
      dly <= 3'(k);
      iss(crs_op_t'(k), 1, 1, 32'h6000_0000, 0);
    end
    chk(n_mem - m, 4);
    wr(CCR1_IDX, 32'h1 << WEAK_ALL_BIT, RESP_OKAY);
    iss(OP_BINARY, 1, 1, 32'h6000_0000, 1);
    wr(CCR1_IDX, 0, RESP_OKAY);
    wr(R_ARR0, 32'h50, RESP_OKAY);
    wr(R_RCR0, 32'h3, RESP_OKAY);
    iss(OP_UNARY, 1, 1, 32'h50aa_0000, 1);
    iss(OP_UNARY, 1, 1, 32'h6000_0000, 0);
    rd(R_IP, ip, RESP_OKAY);
    rd(R_STAT, 32'h0000_0001, RESP_OKAY);
    $display("instructions done");
    summarize();
  end
endmodule
